// ===== hdl/chan_cfg_regs.sv
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
// Overview of operation
// - Config bits 15:6 hold a signed ten-bit sampling skew in modulator cycles.
// - Config bit 2 set disables DC rejection for that channel; clear follows global.
// - Config bits 1:0 route own pins, shorted, positive or negative test signal.
// - Channel 2 input select is its own, resetting to own pin pair.
// - Every configuration register resets to zero.
// - Offset high register holds offset bits 23:8, read/write, resets to zero.
// - Offset low register holds offset bits 7:0 in 15:8; low byte reads zero.
// - Gain high register holds gain bits 23:8 and resets to 8000h.
// - Gain low register holds gain bits 7:0 in 15:8; low byte reads zero.
// - Channel 2 set sits at 13h to 17h, channel 3 config at 18h.
// - Channel 3 config has the same fields, stored independently.
module chan_cfg_regs (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  // AXI4-Lite write address
  input wire logic [chan_cfg_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [chan_cfg_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Global setting from elsewhere in the core
  input wire logic global_dc_reject_setting,
  // Channel 1 tail
  output logic [7:0] chan1_gain_lower,
  // Channel 2 controls
  output logic [chan_cfg_pkg::SKEW_W-1:0] chan2_skew,
  output logic chan2_dc_reject_off,
  output logic chan2_dc_reject_en,
  output chan_cfg_pkg::input_sel_t chan2_input_select,
  output logic [chan_cfg_pkg::CAL_W-1:0] chan2_offset_cal,
  output logic [chan_cfg_pkg::CAL_W-1:0] chan2_gain_cal,
  // Channel 3 controls
  output logic [chan_cfg_pkg::SKEW_W-1:0] chan3_skew,
  output logic chan3_dc_reject_off,
  output logic chan3_dc_reject_en,
  output chan_cfg_pkg::input_sel_t chan3_input_select
);
  import chan_cfg_pkg::*;

  // ************************************************************
  // Storage
  // ************************************************************
  logic [15:0] chan1_gain_low_r, chan1_gain_low_nxt;
  logic [15:0] chan2_config_r, chan2_config_nxt;
  logic [15:0] chan2_offset_high_r, chan2_offset_high_nxt;
  logic [15:0] chan2_offset_low_r, chan2_offset_low_nxt;
  logic [15:0] chan2_gain_high_r, chan2_gain_high_nxt;
  logic [15:0] chan2_gain_low_r, chan2_gain_low_nxt;
  logic [15:0] chan3_config_r, chan3_config_nxt;

  // Bus state
  logic aw_full_r, aw_full_nxt;
  logic w_full_r, w_full_nxt;
  logic [5:0] aw_idx_r, aw_idx_nxt;
  logic [15:0] w_data_r, w_data_nxt;
  logic [1:0] w_strb_r, w_strb_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  logic aw_take, w_take, ar_take, do_write;
  logic [15:0] rd_val;
  logic rd_hit;

  // Byte-lane merge restricted to the writable bits of a register
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] data,
                                        input logic [1:0] strb, input logic [15:0] mask);
    logic [15:0] lanes;
    lanes = {{8{strb[1]}}, {8{strb[0]}}} & mask;
    merge = (old & ~lanes) | (data & lanes);
  endfunction

  // Decode of an index onto its stored value, reserved bits forced low
  function automatic logic [16:0] lookup(input logic [5:0] idx,
                                         input logic [15:0] c1gl, input logic [15:0] c2c,
                                         input logic [15:0] c2oh, input logic [15:0] c2ol,
                                         input logic [15:0] c2gh, input logic [15:0] c2gl,
                                         input logic [15:0] c3c);
    case (idx)
      IDX_CHAN1_GAIN_LOW: lookup = {1'b1, c1gl & LOW_MASK};
      IDX_CHAN2_CONFIG: lookup = {1'b1, c2c & CFG_MASK};
      IDX_CHAN2_OFFSET_HIGH: lookup = {1'b1, c2oh};
      IDX_CHAN2_OFFSET_LOW: lookup = {1'b1, c2ol & LOW_MASK};
      IDX_CHAN2_GAIN_HIGH: lookup = {1'b1, c2gh};
      IDX_CHAN2_GAIN_LOW: lookup = {1'b1, c2gl & LOW_MASK};
      IDX_CHAN3_CONFIG: lookup = {1'b1, c3c & CFG_MASK};
      default: lookup = 17'h00000;
    endcase
  endfunction

  // ************************************************************
  // AXI4-Lite slave
  // ************************************************************
  // Address and data are held separately, so either may arrive first
  assign s_axi_awready = clk_en && !aw_full_r && !bvalid_r;
  assign s_axi_wready = clk_en && !w_full_r && !bvalid_r;
  assign s_axi_arready = clk_en && !rvalid_r;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign do_write = aw_full_r && w_full_r;

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;

  always_comb begin
    logic [16:0] wr_hit;
    logic [16:0] rd_look;
    wr_hit = lookup(aw_idx_r, chan1_gain_low_r, chan2_config_r, chan2_offset_high_r,
                    chan2_offset_low_r, chan2_gain_high_r, chan2_gain_low_r, chan3_config_r);
    rd_look = lookup(s_axi_araddr[ADDR_LSB+5:ADDR_LSB], chan1_gain_low_r, chan2_config_r,
                     chan2_offset_high_r, chan2_offset_low_r, chan2_gain_high_r,
                     chan2_gain_low_r, chan3_config_r);
    rd_hit = rd_look[16];
    rd_val = rd_look[15:0];
    aw_full_nxt = aw_full_r;
    w_full_nxt = w_full_r;
    aw_idx_nxt = aw_idx_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (aw_take) begin
      aw_full_nxt = 1'b1;
      aw_idx_nxt = s_axi_awaddr[ADDR_LSB+5:ADDR_LSB];
    end
    if (w_take) begin
      w_full_nxt = 1'b1;
      w_data_nxt = s_axi_wdata[15:0];
      w_strb_nxt = s_axi_wstrb[1:0];
    end
    if (do_write) begin
      aw_full_nxt = 1'b0;
      w_full_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = wr_hit[16] ? RESP_OKAY : RESP_SLVERR;
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (ar_take) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = rd_hit ? RESP_OKAY : RESP_SLVERR;
      rdata_nxt = {16'h0000, rd_val};
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  // ************************************************************
  // Register writes
  // ************************************************************
  // Masks keep reserved bits at zero in storage, not just on read
  always_comb begin
    chan1_gain_low_nxt = chan1_gain_low_r;
    chan2_config_nxt = chan2_config_r;
    chan2_offset_high_nxt = chan2_offset_high_r;
    chan2_offset_low_nxt = chan2_offset_low_r;
    chan2_gain_high_nxt = chan2_gain_high_r;
    chan2_gain_low_nxt = chan2_gain_low_r;
    chan3_config_nxt = chan3_config_r;
    if (do_write) begin
      case (aw_idx_r)
        IDX_CHAN1_GAIN_LOW: begin
          chan1_gain_low_nxt = merge(chan1_gain_low_r, w_data_r, w_strb_r, LOW_MASK);
        end
        IDX_CHAN2_CONFIG: begin
          chan2_config_nxt = merge(chan2_config_r, w_data_r, w_strb_r, CFG_MASK);
        end
        IDX_CHAN2_OFFSET_HIGH: begin
          chan2_offset_high_nxt = merge(chan2_offset_high_r, w_data_r, w_strb_r,
                                        HIGH_MASK);
        end
        IDX_CHAN2_OFFSET_LOW: begin
          chan2_offset_low_nxt = merge(chan2_offset_low_r, w_data_r, w_strb_r,
                                       LOW_MASK);
        end
        IDX_CHAN2_GAIN_HIGH: begin
          chan2_gain_high_nxt = merge(chan2_gain_high_r, w_data_r, w_strb_r, HIGH_MASK);
        end
        IDX_CHAN2_GAIN_LOW: begin
          chan2_gain_low_nxt = merge(chan2_gain_low_r, w_data_r, w_strb_r, LOW_MASK);
        end
        IDX_CHAN3_CONFIG: begin
          chan3_config_nxt = merge(chan3_config_r, w_data_r, w_strb_r, CFG_MASK);
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      chan1_gain_low_r <= GAIN_LOW_RST;
      chan2_config_r <= CFG_RST;
      chan2_offset_high_r <= OFFSET_HIGH_RST;
      chan2_offset_low_r <= OFFSET_LOW_RST;
      chan2_gain_high_r <= GAIN_HIGH_RST;
      chan2_gain_low_r <= GAIN_LOW_RST;
      chan3_config_r <= CFG_RST;
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      aw_idx_r <= 6'h00;
      w_data_r <= 16'h0000;
      w_strb_r <= 2'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h00000000;
    end else if (clk_en) begin
      chan1_gain_low_r <= chan1_gain_low_nxt;
      chan2_config_r <= chan2_config_nxt;
      chan2_offset_high_r <= chan2_offset_high_nxt;
      chan2_offset_low_r <= chan2_offset_low_nxt;
      chan2_gain_high_r <= chan2_gain_high_nxt;
      chan2_gain_low_r <= chan2_gain_low_nxt;
      chan3_config_r <= chan3_config_nxt;
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      aw_idx_r <= aw_idx_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ************************************************************
  // Channel controls
  // ************************************************************
  // Readies drop while frozen so no beat looks taken that the state cannot hold;
  // responses keep standing then, so a master should not release them while frozen.
  assign chan1_gain_lower = chan1_gain_low_r[LOW_HI:LOW_LO];
  assign chan2_skew = chan2_config_r[SKEW_HI:SKEW_LO];
  assign chan2_dc_reject_off = chan2_config_r[DC_OFF_BIT];
  assign chan2_dc_reject_en = global_dc_reject_setting && !chan2_dc_reject_off;
  assign chan2_input_select = input_sel_t'(chan2_config_r[SEL_HI:SEL_LO]);
  assign chan2_offset_cal = {chan2_offset_high_r, chan2_offset_low_r[LOW_HI:LOW_LO]};
  assign chan2_gain_cal = {chan2_gain_high_r, chan2_gain_low_r[LOW_HI:LOW_LO]};
  assign chan3_skew = chan3_config_r[SKEW_HI:SKEW_LO];
  assign chan3_dc_reject_off = chan3_config_r[DC_OFF_BIT];
  assign chan3_dc_reject_en = global_dc_reject_setting && !chan3_dc_reject_off;
  assign chan3_input_select = input_sel_t'(chan3_config_r[SEL_HI:SEL_LO]);

endmodule

// ===== pkg/chan_cfg_pkg.sv
package chan_cfg_pkg;

  // ************************************************************
  // Register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [5:0] IDX_CHAN1_GAIN_LOW = 6'h12;
  localparam logic [5:0] IDX_CHAN2_CONFIG = 6'h13;
  localparam logic [5:0] IDX_CHAN2_OFFSET_HIGH = 6'h14;
  localparam logic [5:0] IDX_CHAN2_OFFSET_LOW = 6'h15;
  localparam logic [5:0] IDX_CHAN2_GAIN_HIGH = 6'h16;
  localparam logic [5:0] IDX_CHAN2_GAIN_LOW = 6'h17;
  localparam logic [5:0] IDX_CHAN3_CONFIG = 6'h18;
  localparam int ADDR_LSB = 2;
  localparam int ADDR_W = 8;

  // ************************************************************
  // Field layout
  // ************************************************************
  localparam int SKEW_HI = 15;
  localparam int SKEW_LO = 6;
  localparam int SKEW_W = 10;
  localparam int DC_OFF_BIT = 2;
  localparam int SEL_HI = 1;
  localparam int SEL_LO = 0;
  localparam int CAL_W = 24;
  localparam int LOW_HI = 15;
  localparam int LOW_LO = 8;

  // Writable bits per register kind
  localparam logic [15:0] CFG_MASK = 16'hffc7;
  localparam logic [15:0] HIGH_MASK = 16'hffff;
  localparam logic [15:0] LOW_MASK = 16'hff00;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [15:0] CFG_RST = 16'h0000;
  localparam logic [15:0] OFFSET_HIGH_RST = 16'h0000;
  localparam logic [15:0] OFFSET_LOW_RST = 16'h0000;
  localparam logic [15:0] GAIN_HIGH_RST = 16'h8000;
  localparam logic [15:0] GAIN_LOW_RST = 16'h0000;

  // ************************************************************
  // Input routing codes
  // ************************************************************
  typedef enum logic [1:0] {
    SEL_OWN_PINS = 2'h0,
    SEL_SHORTED = 2'h1,
    SEL_POS_TEST = 2'h2,
    SEL_NEG_TEST = 2'h3
  } input_sel_t;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== testbench/chan_cfg_regs_asserts.sv
`timescale 1ns/1ps
// ************************************************************
// Register output and read data checks
// ************************************************************
module chan_cfg_regs_asserts (
  // Watched ports
  input wire logic clk,
  input wire logic rst,
  input wire logic s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic global_dc_reject_setting,
  input wire logic [chan_cfg_pkg::SKEW_W-1:0] chan2_skew,
  input wire logic chan2_dc_reject_off,
  input wire logic chan2_dc_reject_en,
  input chan_cfg_pkg::input_sel_t chan2_input_select,
  input wire logic [chan_cfg_pkg::CAL_W-1:0] chan2_offset_cal,
  input wire logic [chan_cfg_pkg::CAL_W-1:0] chan2_gain_cal,
  input wire logic [chan_cfg_pkg::SKEW_W-1:0] chan3_skew,
  input wire logic chan3_dc_reject_off,
  input wire logic chan3_dc_reject_en
);
  import chan_cfg_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  dc2_follow_a:
    assert property (chan2_dc_reject_en == (global_dc_reject_setting && !chan2_dc_reject_off))
    else $error("chan2 dc reject enable wrong");
  dc3_follow_a:
    assert property (chan3_dc_reject_en == (global_dc_reject_setting && !chan3_dc_reject_off))
    else $error("chan3 dc reject enable wrong");
  cfg_reset_a:
    assert property ($fell(rst) |-> chan2_skew == '0 && !chan2_dc_reject_off
      && chan2_input_select == SEL_OWN_PINS && chan3_skew == '0)
    else $error("config not zero after reset");
  cal_reset_a:
    assert property ($fell(rst) |-> chan2_gain_cal == 24'h800000 && chan2_offset_cal == '0)
    else $error("calibration reset value wrong");
  offset_write_a:
    assert property (!$past(rst) && $changed(chan2_offset_cal) |-> $rose(s_axi_bvalid))
    else $error("offset changed without write");
  gain_write_a:
    assert property (!$past(rst) && $changed(chan2_gain_cal) |-> $rose(s_axi_bvalid))
    else $error("gain changed without write");
  sel2_write_a:
    assert property (!$past(rst) && $changed({chan2_skew, chan2_input_select})
      |-> $rose(s_axi_bvalid))
    else $error("chan2 config changed without write");
  cfg3_write_a:
    assert property (!$past(rst) && $changed({chan3_skew, chan3_dc_reject_off})
      |-> $rose(s_axi_bvalid))
    else $error("chan3 config changed without write");
  rd_upper_a:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  wr_seen_c: cover property ($rose(s_axi_bvalid));
  rd_seen_c: cover property ($rose(s_axi_rvalid));
  err_seen_c: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule
bind chan_cfg_regs chan_cfg_regs_asserts chk_i (.clk, .rst, .s_axi_bvalid, .s_axi_bresp,
  .s_axi_rvalid, .s_axi_rdata, .global_dc_reject_setting, .chan2_skew, .chan2_dc_reject_off,
  .chan2_dc_reject_en, .chan2_input_select, .chan2_offset_cal, .chan2_gain_cal, .chan3_skew,
  .chan3_dc_reject_off, .chan3_dc_reject_en);

// ===== testbench/chan_cfg_regs_tb.sv
`timescale 1ns/1ps
module chan_cfg_regs_tb;
  import chan_cfg_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  // Response readies stay high so no release races a new request
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic global_dc_reject_setting = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rd_data;
  logic [7:0] chan1_gain_lower;
  logic [SKEW_W-1:0] chan2_skew, chan3_skew;
  logic chan2_dc_reject_off, chan2_dc_reject_en, chan3_dc_reject_off, chan3_dc_reject_en;
  input_sel_t chan2_input_select, chan3_input_select;
  logic [CAL_W-1:0] chan2_offset_cal, chan2_gain_cal;
  logic aw_t, w_t, done;
  int errors = 0, samples_checked = 0, cycles = 0;

  chan_cfg_regs dut (.clk, .rst, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .global_dc_reject_setting, .chan1_gain_lower, .chan2_skew,
    .chan2_dc_reject_off, .chan2_dc_reject_en, .chan2_input_select, .chan2_offset_cal,
    .chan2_gain_cal, .chan3_skew, .chan3_dc_reject_off, .chan3_dc_reject_en, .chan3_input_select);

  initial forever #5 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      errors++;
      results();
    end
  end

  // ************************************************************
  // Bus tasks: handshakes judged at the falling edge, inputs moved after the rising edge
  // ************************************************************
  task automatic results;
    if (errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(negedge clk);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t = s_axi_wvalid && s_axi_wready;
      done = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge clk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
    end
  endtask

  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(negedge clk);
      aw_t = s_axi_arvalid && s_axi_arready;
      done = s_axi_rvalid;
      rd_data = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge clk);
      if (aw_t) s_axi_arvalid <= 1'b0;
    end
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset;
    for (int i = 0; i < 7; i++) begin
      rd({IDX_CHAN1_GAIN_LOW + 6'(i), 2'b00});
      chk("reset value", rd_data, (i == 4) ? 32'h0000_8000 : 32'h0000_0000);
      chk("read resp", {30'h0, resp}, {30'h0, RESP_OKAY});
    end
    chk("gain cal reset", {8'h00, chan2_gain_cal}, 32'h0080_0000);
  endtask

  task automatic t_cfg;
    logic [15:0] v;
    for (int s = 0; s < 4; s++) begin
      v = {10'h200 + 10'(s), 3'h7, s[0], s[1:0]};
      wr({IDX_CHAN2_CONFIG, 2'b00}, v);
      rd({IDX_CHAN2_CONFIG, 2'b00});
      chk("chan2 config", rd_data, {16'h0000, v & 16'hffc7});
      chk("chan2 skew", {22'h0, chan2_skew}, {22'h0, 10'h200 + 10'(s)});
      chk("chan2 select", {30'h0, chan2_input_select}, 32'(s));
      chk("chan2 dc off", {31'h0, chan2_dc_reject_off}, 32'(s % 2));
      chk("chan3 skew", {22'h0, chan3_skew}, 32'h0);
    end
    global_dc_reject_setting <= 1'b1;
    @(negedge clk);
    chk("chan2 dc en", {31'h0, chan2_dc_reject_en}, 32'h0);
    chk("chan3 dc en", {31'h0, chan3_dc_reject_en}, 32'h1);
    @(posedge clk);
    wr({IDX_CHAN3_CONFIG, 2'b00}, 16'h7fc6);
    chk("chan3 skew", {22'h0, chan3_skew}, 32'h0000_01ff);
    chk("chan3 select", {30'h0, chan3_input_select}, 32'h2);
    chk("chan3 dc off", {31'h0, chan3_dc_reject_off}, 32'h1);
    chk("chan3 dc en off", {31'h0, chan3_dc_reject_en}, 32'h0);
    chk("chan2 kept", {22'h0, chan2_skew}, 32'h0000_0203);
  endtask

  task automatic t_cal;
    wr({IDX_CHAN2_OFFSET_HIGH, 2'b00}, 16'ha5c3);
    wr({IDX_CHAN2_OFFSET_LOW, 2'b00}, 16'h96ff);
    wr({IDX_CHAN2_GAIN_HIGH, 2'b00}, 16'h7e01);
    wr({IDX_CHAN2_GAIN_LOW, 2'b00}, 16'h3cff);
    chk("write resp", {30'h0, resp}, {30'h0, RESP_OKAY});
    rd({IDX_CHAN2_OFFSET_LOW, 2'b00});
    chk("offset low", rd_data, 32'h0000_9600);
    rd({IDX_CHAN2_GAIN_LOW, 2'b00});
    chk("gain low", rd_data, 32'h0000_3c00);
    rd({IDX_CHAN2_OFFSET_HIGH, 2'b00});
    chk("offset high", rd_data, 32'h0000_a5c3);
    chk("offset cal", {8'h00, chan2_offset_cal}, 32'h00a5_c396);
    chk("gain cal", {8'h00, chan2_gain_cal}, 32'h007e_013c);
    s_axi_wstrb <= 4'h2;
    wr({IDX_CHAN2_OFFSET_HIGH, 2'b00}, 16'h1234);
    s_axi_wstrb <= 4'hf;
    chk("offset upper lane", {8'h00, chan2_offset_cal}, 32'h0012_c396);
  endtask

  task automatic t_freeze;
    clk_en <= 1'b0;
    fork
      wr({IDX_CHAN2_GAIN_HIGH, 2'b00}, 16'h8001);
      begin
        repeat (3) @(posedge clk);
        chk("frozen gain", {8'h00, chan2_gain_cal}, 32'h007e_013c);
        chk("frozen awready", {31'h0, s_axi_awready}, 32'h0);
        clk_en <= 1'b1;
      end
    join
    chk("gain after freeze", {8'h00, chan2_gain_cal}, 32'h0080_013c);
  endtask

  task automatic t_unmapped;
    wr(8'h64, 16'hffff);
    chk("unmapped write", {30'h0, resp}, {30'h0, RESP_SLVERR});
    rd(8'h64);
    chk("unmapped read", rd_data, 32'h0);
    chk("unmapped rresp", {30'h0, resp}, {30'h0, RESP_SLVERR});
    rd({IDX_CHAN3_CONFIG, 2'b00});
    chk("chan3 intact", rd_data, 32'h0000_7fc6);
    wr({IDX_CHAN1_GAIN_LOW, 2'b00}, 16'h5aff);
    chk("chan1 gain lower", {24'h0, chan1_gain_lower}, 32'h0000_005a);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_cfg();
    t_cal();
    t_freeze();
    t_unmapped();
    results();
  end
endmodule
